// ### acml_pkg.sv
package acml_pkg;

	// ------------------------------------------------------------
	// Motion channels
	// ------------------------------------------------------------
	localparam int NCH        = 3;
	localparam int CH_AXIS    = 0;
	localparam int CH_VECTOR  = 1;
	localparam int CH_VIRTUAL = 2;

	// ------------------------------------------------------------
	// Commutation angle, 1/32 degree per step
	// ------------------------------------------------------------
	localparam int ANG_W    = 14;
	localparam int ANG_FRAC = 16;
	localparam logic [13:0]        ANG_FULL    = 14'h2D00;
	localparam logic [13:0]        ANG_DEFAULT = 14'h00C0;
	localparam logic signed [32:0] ANG_FULL_FX = 33'h02D000000;
	localparam logic [15:0]        ANG_FRAC_ZERO = 16'h0000;

	// ------------------------------------------------------------
	// Hall inputs
	// ------------------------------------------------------------
	localparam logic [13:0] HALL_SECTOR      = 14'h0780;
	localparam logic [2:0]  HALL_NONE        = 3'h0;
	localparam logic [2:0]  HALL_BAD         = 3'h7;
	localparam logic        HALL_SEL_DEFAULT = 1'b0;

	// ------------------------------------------------------------
	// Reverse software limit
	// ------------------------------------------------------------
	localparam logic signed [31:0] LIM_DEFAULT = 32'h80000000;
	localparam logic [4:0]         LIM_GRACE   = 5'h10;

	// ------------------------------------------------------------
	// Profile states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ACML_IDLE = 3'b001,
		ACML_RUN  = 3'b010,
		ACML_STOP = 3'b100
	} acml_state_t;

endpackage

// ### acml_hall.sv
module acml_hall (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	// Hall inputs and setting
	input  wire logic        i_sel,
	input  wire logic        i_hall_a,
	input  wire logic        i_hall_b,
	input  wire logic        i_hall_c,
	input  wire logic        i_cal_arm,
	// State and phase result
	output logic [2:0]       o_state,
	output logic             o_valid,
	output logic             o_init_stb,
	output logic [13:0]      o_init_val
);

	function automatic logic code_ok(input logic [2:0] c);
		return (c != acml_pkg::HALL_NONE) && (c != acml_pkg::HALL_BAD);
	endfunction

	function automatic logic [13:0] sector_angle(input logic [2:0] c);
		case (c)
			3'h1: sector_angle = 14'h0000;
			3'h3: sector_angle = acml_pkg::HALL_SECTOR;
			3'h2: sector_angle = 14'((acml_pkg::HALL_SECTOR) * 2);
			3'h6: sector_angle = 14'((acml_pkg::HALL_SECTOR) * 3);
			3'h4: sector_angle = 14'((acml_pkg::HALL_SECTOR) * 4);
			3'h5: sector_angle = 14'((acml_pkg::HALL_SECTOR) * 5);
			default: sector_angle = 14'h0000;
		endcase
	endfunction

	logic [2:0]  raw;
	logic [2:0]  next_state;
	logic        next_valid;
	logic        armed;
	logic        next_armed;
	logic        next_init_stb;
	logic [13:0] next_init_val;

	always_comb begin
		raw = i_sel ? {i_hall_c, i_hall_b, i_hall_a} : acml_pkg::HALL_NONE;
		next_state    = raw;
		next_valid    = code_ok(raw);
		next_armed    = armed | i_cal_arm;
		next_init_stb = 1'b0;
		next_init_val = o_init_val;
		if (armed && code_ok(raw) && code_ok(o_state) && raw != o_state) begin
			next_init_stb = 1'b1;
			next_init_val = sector_angle(raw);
			next_armed    = i_cal_arm;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_state    <= acml_pkg::HALL_NONE;
			o_valid    <= 1'b0;
			armed      <= 1'b0;
			o_init_stb <= 1'b0;
			o_init_val <= 14'h0000;
		end else if (i_ce) begin
			o_state    <= next_state;
			o_valid    <= next_valid;
			armed      <= next_armed;
			o_init_stb <= next_init_stb;
			o_init_val <= next_init_val;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	hall_valid_a: assert property (o_valid |-> o_state inside {[3'h1:3'h6]})
		else $error("hall valid with bad code");
	hall_sel_a: assert property (i_ce && !i_sel |=> o_state == 3'h0 && !o_valid)
		else $error("hall code seen while deselected");
	hall_cal_c: cover property (o_init_stb);

endmodule

// ### acml_phase.sv
module acml_phase (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	// Manual angle write
	input  wire logic        i_wr,
	input  wire logic [13:0] i_wr_val,
	// Phase initialization result
	input  wire logic        i_init_stb,
	input  wire logic [13:0] i_init_val,
	// Axis position and scale
	input  wire logic [31:0] i_pos,
	input  wire logic [31:0] i_per_count,
	// Present phase
	output logic [13:0]      o_angle
);

	logic [29:0]        acc;
	logic [29:0]        next_acc;
	logic [31:0]        last_pos;
	logic               inited;
	logic               next_inited;
	logic signed [15:0] delta;
	logic signed [48:0] prod;
	logic signed [32:0] sum;
	logic [13:0]        wr_clip;

	always_comb begin
		delta   = 16'(i_pos - last_pos);
		prod    = delta * $signed({1'b0, i_per_count});
		sum     = $signed({3'b000, acc}) + $signed(prod[32:0]);
		wr_clip = (i_wr_val > acml_pkg::ANG_FULL) ? acml_pkg::ANG_FULL : i_wr_val;
		next_acc    = acc;
		next_inited = inited;
		if (i_wr) begin
			next_acc    = {wr_clip, acml_pkg::ANG_FRAC_ZERO};
			next_inited = 1'b1;
		end else if (i_init_stb) begin
			next_acc    = {i_init_val, acml_pkg::ANG_FRAC_ZERO};
			next_inited = 1'b1;
		end else if (inited) begin
			if (sum < 0)
				next_acc = 30'(sum + acml_pkg::ANG_FULL_FX);
			else if (sum > acml_pkg::ANG_FULL_FX)
				next_acc = 30'(sum - acml_pkg::ANG_FULL_FX);
			else
				next_acc = 30'(sum);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			acc      <= {acml_pkg::ANG_DEFAULT, acml_pkg::ANG_FRAC_ZERO};
			last_pos <= 32'h00000000;
			inited   <= 1'b0;
			o_angle  <= acml_pkg::ANG_DEFAULT;
		end else if (i_ce) begin
			acc      <= next_acc;
			last_pos <= i_pos;
			inited   <= next_inited;
			o_angle  <= next_acc[29:16];
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	angle_write_a: assert property (i_ce && i_wr |=>
		o_angle == (($past(i_wr_val) > acml_pkg::ANG_FULL) ? acml_pkg::ANG_FULL : $past(i_wr_val)))
		else $error("written angle not taken");
	angle_range_a: assert property (o_angle <= acml_pkg::ANG_FULL)
		else $error("angle beyond full turn");
	angle_hold_a: assert property (!inited && !i_wr && !i_init_stb |=> $stable(o_angle))
		else $error("angle moved before init");

endmodule

// ### acml_axis_ctrl.sv
// Overview of operation
// - Writing the commutation angle sets the sine phase directly.
// - Angle spans 0 to 360 degrees in 1/32 steps, default 6.
// - A manual angle write overrides any initialization-derived phase.
// - Once initialized, the stored angle follows the electrical phase.
// - Angle readback returns the present commutation phase.
// - Begin-motion starts any mix of axis, vector plane, virtual axis.
// - Begin-motion is refused for a channel still in motion.
// - Geared axis still accepts begin-motion, superimposing a profiled move.
// - Motion-in-progress reads 0 when complete, 1 while moving.
// - Hall select routes dedicated hall inputs or clears the configuration.
// - Exceeding the reverse limit in motion decelerates the axis to stop.
// - Reverse motion beyond the reverse limit is not permitted; here it trips only after a 16-cycle begin-motion grace.
// - Limit trips at n-1; the most negative value disables it.
// - Reverse limit is signed 32-bit, defaulting to most negative.
// - Limit compares encoder counts for servo, microsteps for stepper.
// - Limit activation raises an event for the limit handler routine.
// - Motion started past the limit profiles a short move first.
// - Hall codes 1 to 6 are valid; 0 and 7 are invalid.
module acml_axis_ctrl #(
	parameter int NCH = acml_pkg::NCH
) (
	// Clock, reset, enable
	input  wire logic                   I_REF_CLK,
	input  wire logic                   I_RST_N,
	input  wire logic                   I_CE,
	// Begin-motion command
	input  wire logic                   I_BG_STB,
	input  wire logic [NCH-1:0]         I_BG_MASK,
	input  wire logic [NCH-1:0][31:0]   I_MOVE_DIST,
	input  wire logic [NCH-1:0][15:0]   I_SPEED,
	input  wire logic [NCH-1:0][15:0]   I_ACCEL,
	// Gearing
	input  wire logic                   I_GEAR_EN,
	input  wire logic signed [15:0]     I_GEAR_VEL,
	// Axis position
	input  wire logic [31:0]            I_ENC_POS,
	input  wire logic [31:0]            I_STEP_POS,
	input  wire logic                   I_STEPPER,
	// Reverse limit setting
	input  wire logic                   I_REV_LIMIT_WR,
	input  wire logic [31:0]            I_REV_LIMIT_VAL,
	// Commutation angle
	input  wire logic                   I_ANGLE_WR,
	input  wire logic [13:0]            I_ANGLE_VAL,
	input  wire logic [31:0]            I_ANGLE_PER_COUNT,
	input  wire logic                   I_PHASE_INIT_STB,
	input  wire logic [13:0]            I_PHASE_INIT_VAL,
	// Hall inputs and setting
	input  wire logic                   I_HALL_SEL_WR,
	input  wire logic                   I_HALL_SEL_DED,
	input  wire logic                   I_HALL_CAL_ARM,
	input  wire logic                   I_HALL_A,
	input  wire logic                   I_HALL_B,
	input  wire logic                   I_HALL_C,
	// Motion status
	output logic [NCH-1:0]              O_MOTION_BUSY,
	output logic [NCH-1:0]              O_BG_REFUSED,
	output logic [NCH-1:0][16:0]        O_CH_VEL,
	output logic signed [17:0]          O_AXIS_VEL,
	// Limit status
	output logic [31:0]                 O_REV_LIMIT,
	output logic                        O_LIMIT_ACTIVE,
	output logic                        O_LIMIT_EVENT,
	// Commutation and hall status
	output logic [13:0]                 O_ANGLE,
	output logic                        O_HALL_SEL,
	output logic [2:0]                  O_HALL_STATE,
	output logic                        O_HALL_VALID
);

	// ------------------------------------------------------------
	// Settings
	// ------------------------------------------------------------
	logic              next_hall_sel;
	logic signed [31:0] rev_lim;
	logic signed [31:0] next_rev_lim;

	always_comb begin
		next_hall_sel = O_HALL_SEL;
		next_rev_lim  = rev_lim;
		if (I_HALL_SEL_WR)
			next_hall_sel = I_HALL_SEL_DED;
		if (I_REV_LIMIT_WR)
			next_rev_lim = I_REV_LIMIT_VAL;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			O_HALL_SEL  <= acml_pkg::HALL_SEL_DEFAULT;
			rev_lim     <= acml_pkg::LIM_DEFAULT;
			O_REV_LIMIT <= acml_pkg::LIM_DEFAULT;
		end else if (I_CE) begin
			O_HALL_SEL  <= next_hall_sel;
			rev_lim     <= next_rev_lim;
			O_REV_LIMIT <= next_rev_lim;
		end
	end

	// ------------------------------------------------------------
	// Reverse limit check
	// ------------------------------------------------------------
	logic signed [31:0] axis_pos;
	logic               lim_on;
	logic               lim_past;
	logic               lim_trip;
	logic               tripped;
	logic               next_tripped;
	logic               next_event;
	logic               next_active;
	logic [4:0]         grace;
	logic [4:0]         next_grace;
	logic [NCH-1:0]     start;
	logic [NCH-1:0]     run_rev;

	assign axis_pos = I_STEPPER ? I_STEP_POS : I_ENC_POS;
	assign lim_on   = rev_lim != acml_pkg::LIM_DEFAULT;
	assign lim_past = axis_pos < rev_lim;
	assign lim_trip = lim_on & lim_past & run_rev[acml_pkg::CH_AXIS] & (grace == 5'h00);

	always_comb begin
		next_grace = grace;
		if (start[acml_pkg::CH_AXIS])
			next_grace = acml_pkg::LIM_GRACE;
		else if (grace != 5'h00)
			next_grace = grace - 5'h01;
		next_tripped = lim_trip;
		next_event   = lim_trip & ~tripped;
		next_active  = lim_on & lim_past;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			grace          <= 5'h00;
			tripped        <= 1'b0;
			O_LIMIT_EVENT  <= 1'b0;
			O_LIMIT_ACTIVE <= 1'b0;
		end else if (I_CE) begin
			grace          <= next_grace;
			tripped        <= next_tripped;
			O_LIMIT_EVENT  <= next_event;
			O_LIMIT_ACTIVE <= next_active;
		end
	end

	// ------------------------------------------------------------
	// Motion profile per channel
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : chan
			acml_pkg::acml_state_t st;
			acml_pkg::acml_state_t next_st;
			logic [31:0]        rem;
			logic [31:0]        next_rem;
			logic [31:0]        acc;
			logic [31:0]        next_acc;
			logic [15:0]        v;
			logic [15:0]        next_v;
			logic               dir;
			logic               next_dir;
			logic               req;
			logic               abort;
			logic               next_busy;
			logic               next_ref;
			logic [16:0]        next_vel;
			logic [15:0]        step;
			logic [31:0]        rem_left;
			logic [15:0]        spd;
			logic [15:0]        acl;
			logic [16:0]        v_up;

			assign req        = I_BG_STB & I_BG_MASK[g];
			assign abort      = (g == acml_pkg::CH_AXIS) && lim_trip;
			assign start[g]   = req & (st == acml_pkg::ACML_IDLE);
			assign run_rev[g] = (st == acml_pkg::ACML_RUN) & dir;

			always_comb begin
				spd      = (I_SPEED[g] == 16'h0000) ? 16'h0001 : I_SPEED[g];
				acl      = (I_ACCEL[g] == 16'h0000) ? 16'h0001 : I_ACCEL[g];
				step     = (rem < {16'h0000, v}) ? rem[15:0] : v;
				rem_left = rem - {16'h0000, step};
				v_up     = {1'b0, v} + {1'b0, acl};
				next_st  = st;
				next_rem = rem;
				next_acc = acc;
				next_v   = v;
				next_dir = dir;
				next_vel = 17'h00000;
				next_ref = req & (st != acml_pkg::ACML_IDLE);
				case (st)
					acml_pkg::ACML_IDLE: begin
						if (req) begin
							next_dir = I_MOVE_DIST[g][31];
							next_rem = next_dir ? (~I_MOVE_DIST[g] + 32'h00000001) : I_MOVE_DIST[g];
							next_v   = 16'h0000;
							next_acc = 32'h00000000;
							if (I_MOVE_DIST[g] != 32'h00000000)
								next_st = acml_pkg::ACML_RUN;
						end
					end
					acml_pkg::ACML_RUN: begin
						next_rem = rem_left;
						next_vel = dir ? 17'(-{1'b0, step}) : {1'b0, step};
						if (rem_left == 32'h00000000) begin
							next_st = acml_pkg::ACML_IDLE;
							next_v  = 16'h0000;
						end else if (abort) begin
							next_st = acml_pkg::ACML_STOP;
						end else if (rem_left <= acc) begin
							next_v = (v > acl) ? v - acl : 16'h0001;
						end else if (v < spd) begin
							next_v   = (v_up > {1'b0, spd}) ? spd : v_up[15:0];
							next_acc = acc + {16'h0000, next_v};
						end
					end
					acml_pkg::ACML_STOP: begin
						next_rem = rem_left;
						next_vel = dir ? 17'(-{1'b0, step}) : {1'b0, step};
						next_v   = (v > acl) ? v - acl : 16'h0000;
						if (rem_left == 32'h00000000 || next_v == 16'h0000) begin
							next_st = acml_pkg::ACML_IDLE;
							next_v  = 16'h0000;
						end
					end
					default: begin
						next_st = acml_pkg::ACML_IDLE;
					end
				endcase
				next_busy = next_st != acml_pkg::ACML_IDLE;
			end

			always_ff @(posedge I_REF_CLK) begin
				if (!I_RST_N) begin
					st               <= acml_pkg::ACML_IDLE;
					rem              <= 32'h00000000;
					acc              <= 32'h00000000;
					v                <= 16'h0000;
					dir              <= 1'b0;
					O_MOTION_BUSY[g] <= 1'b0;
					O_BG_REFUSED[g]  <= 1'b0;
					O_CH_VEL[g]      <= 17'h00000;
				end else if (I_CE) begin
					st               <= next_st;
					rem              <= next_rem;
					acc              <= next_acc;
					v                <= next_v;
					dir              <= next_dir;
					O_MOTION_BUSY[g] <= next_busy;
					O_BG_REFUSED[g]  <= next_ref;
					O_CH_VEL[g]      <= next_vel;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Axis drive velocity with gearing added
	// ------------------------------------------------------------
	logic signed [17:0] next_axis_vel;

	always_comb begin
		next_axis_vel = 18'($signed(O_CH_VEL[acml_pkg::CH_AXIS]));
		if (I_GEAR_EN)
			next_axis_vel = next_axis_vel + 18'(I_GEAR_VEL);
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N)
			O_AXIS_VEL <= 18'h00000;
		else if (I_CE)
			O_AXIS_VEL <= next_axis_vel;
	end

	// ------------------------------------------------------------
	// Commutation and hall
	// ------------------------------------------------------------
	logic        hall_init_stb;
	logic [13:0] hall_init_val;

	acml_hall u_hall (
		.i_clk      (I_REF_CLK),
		.i_rst_n    (I_RST_N),
		.i_ce       (I_CE),
		.i_sel      (O_HALL_SEL),
		.i_hall_a   (I_HALL_A),
		.i_hall_b   (I_HALL_B),
		.i_hall_c   (I_HALL_C),
		.i_cal_arm  (I_HALL_CAL_ARM),
		.o_state    (O_HALL_STATE),
		.o_valid    (O_HALL_VALID),
		.o_init_stb (hall_init_stb),
		.o_init_val (hall_init_val)
	);

	acml_phase u_phase (
		.i_clk       (I_REF_CLK),
		.i_rst_n     (I_RST_N),
		.i_ce        (I_CE),
		.i_wr        (I_ANGLE_WR),
		.i_wr_val    (I_ANGLE_VAL),
		.i_init_stb  (I_PHASE_INIT_STB | hall_init_stb),
		.i_init_val  (I_PHASE_INIT_STB ? I_PHASE_INIT_VAL : hall_init_val),
		.i_pos       (axis_pos),
		.i_per_count (I_ANGLE_PER_COUNT),
		.o_angle     (O_ANGLE)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);

	bg_refuse_a: assert property (I_CE && I_BG_STB && I_BG_MASK[0] && O_MOTION_BUSY[0]
		|=> O_BG_REFUSED[0] && O_MOTION_BUSY[0])
		else $error("busy axis accepted begin");
	bg_start_a: assert property (I_CE && start[0] && I_MOVE_DIST[0] != 32'h0
		|=> O_MOTION_BUSY[0] && !O_BG_REFUSED[0])
		else $error("begin did not start motion");
	idle_vel_a: assert property (I_CE && !O_MOTION_BUSY[1] && !start[1]
		|=> O_CH_VEL[1] == 17'h0)
		else $error("idle channel moving");
	limit_stop_a: assert property (I_CE && lim_trip |=> chan[0].st == acml_pkg::ACML_STOP)
		else $error("limit did not decelerate");
	limit_event_a: assert property (I_CE && lim_trip && !tripped |=> O_LIMIT_EVENT)
		else $error("limit event missing");
	limit_off_a: assert property (rev_lim == acml_pkg::LIM_DEFAULT |-> !lim_trip)
		else $error("disabled limit tripped");
	limit_grace_a: assert property (I_CE && start[0] |=> !lim_trip [*8])
		else $error("limit tripped during grace");
	limit_reset_a: assert property ($rose(I_RST_N) |-> rev_lim == acml_pkg::LIM_DEFAULT)
		else $error("limit not off after reset");
	limit_src_a: assert property (lim_trip |->
		$signed(I_STEPPER ? I_STEP_POS : I_ENC_POS) < rev_lim)
		else $error("limit from wrong position");

	limit_trip_c: cover property (O_LIMIT_EVENT);
	bg_refused_c: cover property (O_BG_REFUSED[0]);
	geared_move_c: cover property (I_GEAR_EN && start[0]);
	mixed_begin_c: cover property (start[0] && start[1] && start[2]);

endmodule

// ### acml_motor_model.sv
module acml_motor_model #(
	parameter int USTEP_SHIFT = 1
) (
	// Clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	// Drive and test controls
	input  wire logic signed [17:0] i_vel,
	input  wire logic               i_load,
	input  wire logic [31:0]        i_load_val,
	input  wire logic               i_hall_bad,
	// Sensor outputs
	output logic [31:0]             o_enc_pos,
	output logic [31:0]             o_step_pos,
	output logic                    o_hall_a,
	output logic                    o_hall_b,
	output logic                    o_hall_c
);
	timeunit 1ns;
	timeprecision 1ps;
	// Hall code order, one sector per 16 counts
	localparam logic [2:0] HALL_SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	logic signed [31:0] pos;
	int                 sec;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) pos <= 32'h00000000;
		else if (i_load) pos <= i_load_val;
		else pos <= pos + 32'(i_vel);
	end
	assign sec = ((int'(pos >>> 4) % 6) + 6) % 6;
	assign o_enc_pos = pos;
	assign o_step_pos = pos <<< USTEP_SHIFT;
	assign {o_hall_c, o_hall_b, o_hall_a} = i_hall_bad ? 3'h7 : HALL_SEQ[sec];
endmodule

// ### testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// --------------
	// Signals
	// --------------
	logic               I_REF_CLK, I_RST_N, I_CE, I_BG_STB, I_GEAR_EN, I_STEPPER;
	logic               I_REV_LIMIT_WR, I_ANGLE_WR, I_PHASE_INIT_STB, I_HALL_SEL_WR;
	logic               I_HALL_SEL_DED, I_HALL_CAL_ARM, I_HALL_A, I_HALL_B, I_HALL_C;
	logic               O_LIMIT_ACTIVE, O_LIMIT_EVENT, O_HALL_SEL, O_HALL_VALID, load, hall_bad;
	logic [2:0]         I_BG_MASK, O_MOTION_BUSY, O_BG_REFUSED, O_HALL_STATE;
	logic [2:0][31:0]   I_MOVE_DIST;
	logic [2:0][15:0]   I_SPEED, I_ACCEL;
	logic [2:0][16:0]   ch_vel;
	logic signed [15:0] I_GEAR_VEL;
	logic signed [17:0] O_AXIS_VEL;
	logic [31:0]        I_ENC_POS, I_STEP_POS, I_REV_LIMIT_VAL, I_ANGLE_PER_COUNT;
	logic [31:0]        O_REV_LIMIT, load_val;
	logic [13:0]        I_ANGLE_VAL, I_PHASE_INIT_VAL, O_ANGLE;
	int                 err_count, comparisons;
	acml_axis_ctrl DUT (
		.I_REF_CLK, .I_RST_N, .I_CE, .I_BG_STB, .I_BG_MASK, .I_MOVE_DIST, .I_SPEED, .I_ACCEL,
		.I_GEAR_EN, .I_GEAR_VEL, .I_ENC_POS, .I_STEP_POS, .I_STEPPER, .I_REV_LIMIT_WR,
		.I_REV_LIMIT_VAL, .I_ANGLE_WR, .I_ANGLE_VAL, .I_ANGLE_PER_COUNT, .I_PHASE_INIT_STB,
		.I_PHASE_INIT_VAL, .I_HALL_SEL_WR, .I_HALL_SEL_DED, .I_HALL_CAL_ARM, .I_HALL_A,
		.I_HALL_B, .I_HALL_C, .O_MOTION_BUSY, .O_BG_REFUSED, .O_CH_VEL(ch_vel), .O_AXIS_VEL,
		.O_REV_LIMIT, .O_LIMIT_ACTIVE, .O_LIMIT_EVENT, .O_ANGLE, .O_HALL_SEL, .O_HALL_STATE,
		.O_HALL_VALID
	);
	acml_motor_model MOTOR (
		.i_clk(I_REF_CLK), .i_rst_n(I_RST_N), .i_vel(O_AXIS_VEL), .i_load(load),
		.i_load_val(load_val), .i_hall_bad(hall_bad), .o_enc_pos(I_ENC_POS),
		.o_step_pos(I_STEP_POS), .o_hall_a(I_HALL_A), .o_hall_b(I_HALL_B), .o_hall_c(I_HALL_C)
	);
	// --------------
	// Tasks
	// --------------
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge I_REF_CLK);
	endtask
	task automatic hang(string nm);
		err_count++;
		$display("[ERR] %s expected done seen timeout", nm);
		complete_run();
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 400 && O_MOTION_BUSY !== 3'h0; i++) cyc(1);
		if (O_MOTION_BUSY !== 3'h0) hang("busy");
		cyc(3);
	endtask
	task automatic wait_evt(output int n);
		for (n = 0; n < 80 && O_LIMIT_EVENT !== 1'b1; n++) cyc(1);
		if (O_LIMIT_EVENT !== 1'b1) hang("event");
	endtask
	task automatic start(logic [2:0] m, logic [31:0] d, int n);
		{I_BG_MASK, I_MOVE_DIST, I_BG_STB} = {m, d, d, d, 1'b1};
		cyc(n);
		I_BG_STB = 1'b0;
	endtask
	task automatic put_ang(logic w, logic [13:0] v, logic s, logic [13:0] iv);
		{I_ANGLE_WR, I_ANGLE_VAL, I_PHASE_INIT_STB, I_PHASE_INIT_VAL} = {w, v, s, iv};
		cyc(1);
		{I_ANGLE_WR, I_PHASE_INIT_STB} = 2'h0;
		cyc(1);
	endtask
	task automatic set_lim(logic [31:0] v);
		{I_REV_LIMIT_WR, I_REV_LIMIT_VAL} = {1'b1, v};
		cyc(1);
		I_REV_LIMIT_WR = 1'b0;
		cyc(1);
	endtask
	task automatic put_pos(logic [31:0] v);
		{load, load_val} = {1'b1, v};
		cyc(1);
		load = 1'b0;
		cyc(2);
	endtask
	task automatic hall_sel(logic d);
		{I_HALL_SEL_WR, I_HALL_SEL_DED, hall_bad} = {1'b1, d, 1'b0};
		cyc(1);
		I_HALL_SEL_WR = 1'b0;
		cyc(2);
	endtask
	// --------------
	// Scenarios
	// --------------
	task automatic t_reset();
		chk("angle", 32'(O_ANGLE), 32'(acml_pkg::ANG_DEFAULT));
		chk("limit", O_REV_LIMIT, acml_pkg::LIM_DEFAULT);
		chk("busy", 32'(O_MOTION_BUSY), 32'h0);
		chk("hsel", 32'(O_HALL_SEL), 32'(acml_pkg::HALL_SEL_DEFAULT));
	endtask
	task automatic t_angle();
		put_ang(1'b1, 14'h0C80, 1'b0, 14'h0000);
		chk("ang_wr", 32'(O_ANGLE), 32'h0C80);
		put_ang(1'b1, 14'h3000, 1'b0, 14'h0000);
		chk("ang_clip", 32'(O_ANGLE), 32'(acml_pkg::ANG_FULL));
		put_ang(1'b0, 14'h0000, 1'b1, 14'h0500);
		chk("ang_init", 32'(O_ANGLE), 32'h0500);
		put_ang(1'b1, 14'h0A00, 1'b1, 14'h0700);
		chk("ang_over", 32'(O_ANGLE), 32'h0A00);
		I_CE = 1'b0;
		put_ang(1'b1, 14'h0100, 1'b0, 14'h0000);
		chk("ang_ce", 32'(O_ANGLE), 32'h0A00);
		I_CE = 1'b1;
	endtask
	task automatic t_hall();
		hall_sel(1'b1);
		chk("hsel", 32'(O_HALL_SEL), 32'h1);
		chk("hstate", 32'(O_HALL_STATE), 32'h1);
		chk("hvalid", 32'(O_HALL_VALID), 32'h1);
		{I_HALL_CAL_ARM, hall_bad} = 2'h2;
		cyc(1);
		I_HALL_CAL_ARM = 1'b0;
		put_pos(32'h00000010);
		chk("hcal", 32'(O_ANGLE), 32'(acml_pkg::HALL_SECTOR));
		put_pos(32'h00000000);
		hall_bad = 1'b1;
		cyc(2);
		chk("hbad", 32'(O_HALL_STATE), 32'(acml_pkg::HALL_BAD));
		chk("hbad_valid", 32'(O_HALL_VALID), 32'h0);
		hall_sel(1'b0);
		chk("hclear", 32'(O_HALL_STATE), 32'(acml_pkg::HALL_NONE));
		chk("hclear_valid", 32'(O_HALL_VALID), 32'h0);
	endtask
	task automatic t_motion();
		start(3'h1, 32'h0000000A, 2);
		chk("busy", 32'(O_MOTION_BUSY), 32'h1);
		chk("refused", 32'(O_BG_REFUSED), 32'h1);
		wait_idle();
		chk("pos", I_ENC_POS, 32'h0000000A);
		start(3'h7, 32'h0000000A, 1);
		chk("busy_all", 32'(O_MOTION_BUSY), 32'h7);
		chk("refused_none", 32'(O_BG_REFUSED), 32'h0);
		cyc(2);
		chk("ch_vel", 32'(ch_vel[1]), 32'h2);
		wait_idle();
		chk("pos_all", I_ENC_POS, 32'h00000014);
	endtask
	task automatic t_gear();
		{I_GEAR_EN, I_GEAR_VEL} = {1'b1, 16'h0003};
		cyc(3);
		chk("gear_vel", 32'(O_AXIS_VEL), 32'h3);
		chk("gear_busy", 32'(O_MOTION_BUSY), 32'h0);
		start(3'h1, 32'h0000000A, 1);
		chk("gear_bg", 32'(O_MOTION_BUSY), 32'h1);
		wait_idle();
		I_GEAR_EN = 1'b0;
		cyc(3);
	endtask
	task automatic t_lim_edge();
		int i;
		set_lim(32'hFFFFFFEC);
		chk("limit", O_REV_LIMIT, 32'hFFFFFFEC);
		for (i = 0; i < 4; i++) begin
			I_STEPPER = i[1];
			put_pos((i[1] ? 32'hFFFFFFF6 : 32'hFFFFFFEC) - 32'(i[0]));
			chk("lim_act", 32'(O_LIMIT_ACTIVE), 32'(i[0]));
		end
		I_STEPPER = 1'b0;
		set_lim(acml_pkg::LIM_DEFAULT);
		put_pos(32'hFFFFFC18);
		chk("lim_off", 32'(O_LIMIT_ACTIVE), 32'h0);
		put_pos(32'h00000000);
	endtask
	task automatic t_lim_trip();
		int n;
		set_lim(32'hFFFFFFEC);
		start(3'h1, 32'hFFFFFF9C, 1);
		wait_evt(n);
		chk("event", 32'(O_LIMIT_EVENT), 32'h1);
		wait_idle();
		chk("stop", 32'($signed(I_ENC_POS) > -100), 32'h1);
		chk("lim_act", 32'(O_LIMIT_ACTIVE), 32'h1);
		put_pos(32'hFFFFFFE2);
		start(3'h1, 32'hFFFFFF38, 1);
		chk("past_bg", 32'(O_MOTION_BUSY), 32'h1);
		wait_evt(n);
		chk("past_grace", 32'(n >= 14), 32'h1);
		wait_idle();
		chk("past_stop", 32'($signed(I_ENC_POS) > -230), 32'h1);
	endtask
	task automatic t_track();
		set_lim(acml_pkg::LIM_DEFAULT);
		put_ang(1'b1, 14'h2CC0, 1'b0, 14'h0000);
		I_ANGLE_PER_COUNT = 32'h00200000;
		cyc(2);
		start(3'h1, 32'h0000000A, 1);
		wait_idle();
		chk("ang_track", 32'(O_ANGLE), 32'h0100);
	endtask
	// --------------
	// Main sequence
	// --------------
	initial begin
		I_REF_CLK = 1'b0;
		forever #12.5 I_REF_CLK = ~I_REF_CLK;
	end
	initial begin
		{I_RST_N, I_BG_STB, I_GEAR_EN, I_STEPPER, I_REV_LIMIT_WR, I_ANGLE_WR} = 6'h00;
		{I_PHASE_INIT_STB, I_HALL_SEL_WR, I_HALL_SEL_DED, I_HALL_CAL_ARM} = 4'h0;
		{load, hall_bad, I_BG_MASK, I_MOVE_DIST, I_GEAR_VEL, I_REV_LIMIT_VAL} = '0;
		{I_ANGLE_PER_COUNT, load_val, I_ANGLE_VAL, I_PHASE_INIT_VAL} = '0;
		{I_CE, I_SPEED, I_ACCEL} = {1'b1, {3{16'h0004}}, {3{16'h0002}}};
		err_count = 0;
		comparisons = 0;
		repeat (8) @(negedge I_REF_CLK);
		I_RST_N = 1'b1;
		cyc(1);
		t_reset();
		t_angle();
		t_hall();
		t_motion();
		t_gear();
		t_lim_edge();
		t_lim_trip();
		t_track();
		complete_run();
	end
endmodule
